// *** logic/pft_channel.sv ***
// Purpose: One pulse flowmeter channel: filter, decoder, rate, limits, totalizer.
// Assumes: Counting inputs are asynchronous pins; logical channels are synchronous.
// Notes: Gate window, filter and zero times derive from CLK_HZ; shrink it for simulation.
`timescale 1ns/10ps
`default_nettype none

// Input sync and glitch filter for one counting pin
module pft_filter
(
   // Clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Minimum stable time in cycles, zero means no filter
   input wire logic [31:0] min_cyc,
   // Pin and filtered level
   input wire logic pin,
   output logic lvl
);
   // Three stage synchroniser
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   // Stability counter
   logic [31:0] cnt_reg;

   // Synchroniser chain
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end
      else if (ce)
      begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Level follows only once a change is stable long enough
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_reg <= 32'h0000_0000;
         lvl <= 1'b0;
      end
      else if (ce)
      begin
         if ((s2_reg != s3_reg) || (s3_reg == lvl))
         begin
            // Disagreement or no change restarts the timer
            cnt_reg <= 32'h0000_0000;
         end
         else if (cnt_reg + 32'h0000_0001 >= min_cyc)
         begin
            // Shorter pulses are bounces and vanish
            lvl <= s3_reg;
            cnt_reg <= 32'h0000_0000;
         end
         else
         begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
         end
      end
   end
endmodule

module pft_channel
#(
   parameter int CLK_HZ = pft_pkg::CLK_HZ_DEF
)
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Counting pins
   input wire logic inp1,
   input wire logic inp2,
   // Logical channel sources
   input wire pft_pkg::pft_chan_t chan,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Results to the logical channel system
   output logic signed [31:0] rate,
   output logic signed [31:0] total,
   output logic below_limit_flag,
   output logic above_limit_flag,
   // Interrupt
   output logic irq
);
   // One second gate in cycles
   localparam logic [31:0] GATE_CYC = 32'(CLK_HZ);

   // Configuration and limits
   pft_pkg::pft_cfg_t cfg_reg;
   logic signed [31:0] low_reg;
   logic signed [31:0] high_reg;
   // Filtered levels and their previous values
   logic a_lvl;
   logic b_lvl;
   logic a_prev_reg;
   logic b_prev_reg;
   // Filter threshold
   logic [31:0] min_cyc;
   // Decoded signed step, -1, 0 or +1
   logic signed [1:0] step;
   // Rate measurement
   logic [31:0] gate_reg;
   logic signed [31:0] acc_reg;
   logic [39:0] idle_reg;
   logic [39:0] zero_cyc;
   logic zero_hit;
   // Totalizer controls
   logic tot_clear;
   logic tot_hold;
   logic tot_rev;
   // Interrupt registers
   logic [pft_pkg::EV_W-1:0] ev_stat_reg;
   logic [pft_pkg::EV_W-1:0] ev_en_reg;
   logic [pft_pkg::EV_W-1:0] ev_set;
   logic zero_seen_reg;

   // Filter threshold from the selected cap; disabled passes all
   always_comb
   begin
      min_cyc = 32'h0000_0000;
      if ((cfg_reg.filt != 4'h0) && (cfg_reg.filt <= 4'h8))
      begin
         // Half a period of the cap at square wave
         min_cyc = 32'(CLK_HZ / (2 * pft_pkg::FILT_HZ[cfg_reg.filt]));
      end
   end

   // Both pins share one filter setting
   pft_filter u_filt_a
   (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .min_cyc(min_cyc),
      .pin(inp1),
      .lvl(a_lvl)
   );

   pft_filter u_filt_b
   (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .min_cyc(min_cyc),
      .pin(inp2),
      .lvl(b_lvl)
   );

   // Edge history of the filtered levels
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         a_prev_reg <= 1'b0;
         b_prev_reg <= 1'b0;
      end
      else if (ce)
      begin
         a_prev_reg <= a_lvl;
         b_prev_reg <= b_lvl;
      end
   end

   // Pulse decoder
   always_comb
   begin
      step = 2'sd0;
      case (pft_pkg::pft_mode_t'(cfg_reg.mode))
         pft_pkg::PFT_DIRIN:
         begin
            // Rising edge on input one counts; input two is direction
            if (a_lvl && !a_prev_reg)
            begin
               step = b_lvl ? -2'sd1 : 2'sd1;
            end
         end
         pft_pkg::PFT_QUAD1:
         begin
            // One count per cycle, phase gives sign
            if (a_lvl && !a_prev_reg)
            begin
               step = b_lvl ? -2'sd1 : 2'sd1;
            end
         end
         pft_pkg::PFT_QUAD4:
         begin
            // Every edge of either input counts while the other input holds
            if ((a_lvl != a_prev_reg) && (b_lvl == b_prev_reg))
            begin
               step = (a_lvl != b_lvl) ? 2'sd1 : -2'sd1;
            end
            else if ((b_lvl != b_prev_reg) && (a_lvl == a_prev_reg))
            begin
               step = (a_lvl == b_lvl) ? 2'sd1 : -2'sd1;
            end
            // Both changing at once is an illegal jump and is dropped
         end
         default:
         begin
            step = 2'sd0;
         end
      endcase
   end

   // Zero time in cycles; 64-bit math since CLK_HZ times 10000 ms overflows 32 bits
   always_comb
   begin
      zero_cyc = 40'(64'(CLK_HZ) * 64'(pft_pkg::ZERO_MS[0]) / 64'd1000);
      if (cfg_reg.zsel == 2'h1)
      begin
         zero_cyc = 40'(64'(CLK_HZ) * 64'(pft_pkg::ZERO_MS[1]) / 64'd1000);
      end
      else if (cfg_reg.zsel >= 2'h2)
      begin
         zero_cyc = 40'(64'(CLK_HZ) * 64'(pft_pkg::ZERO_MS[2]) / 64'd1000);
      end
   end
   assign zero_hit = (idle_reg + 40'h00_0000_0001 >= zero_cyc);

   // Cycles since the last pulse
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         idle_reg <= 40'h00_0000_0000;
      end
      else if (ce)
      begin
         if (step != 2'sd0)
         begin
            idle_reg <= 40'h00_0000_0000;
         end
         else if (!zero_hit)
         begin
            idle_reg <= idle_reg + 40'h00_0000_0001;
         end
      end
   end

   // Gate window and rate; hold does not stop this
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         gate_reg <= 32'h0000_0000;
         acc_reg <= 32'sh0000_0000;
         rate <= 32'sh0000_0000;
      end
      else if (ce)
      begin
         if (gate_reg + 32'h0000_0001 >= GATE_CYC)
         begin
            gate_reg <= 32'h0000_0000;
            acc_reg <= 32'(step);
            // Signed count times the time base
            if (cfg_reg.tbase == 2'h1)
            begin
               rate <= 32'(acc_reg * pft_pkg::TBASE_MUL[1]);
            end
            else if (cfg_reg.tbase >= 2'h2)
            begin
               rate <= 32'(acc_reg * pft_pkg::TBASE_MUL[2]);
            end
            else
            begin
               rate <= 32'(acc_reg * pft_pkg::TBASE_MUL[0]);
            end
         end
         else
         begin
            gate_reg <= gate_reg + 32'h0000_0001;
            acc_reg <= acc_reg + 32'(step);
         end
         // Pulse starvation wins over any pending rate
         if (zero_hit)
         begin
            rate <= 32'sh0000_0000;
         end
      end
   end

   // Limit flags follow the displayed rate
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         below_limit_flag <= 1'b0;
         above_limit_flag <= 1'b0;
      end
      else if (ce)
      begin
         below_limit_flag <= (rate < low_reg);
         above_limit_flag <= (rate > high_reg);
      end
   end

   // Totalizer controls from the logical channels
   assign tot_clear = (ce && wr && (addr == pft_pkg::OFS_CMD)
                       && wdata[pft_pkg::CMD_RESET_NOW])
                      || (cfg_reg.rst_en && (chan.rst_val > 0));
   assign tot_hold = cfg_reg.hold_en && (chan.hold_val <= 0);
   assign tot_rev = cfg_reg.dir_en && (chan.dir_val > 0);

   // Totalizer; limit flags never gate accumulation
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         total <= 32'sh0000_0000;
      end
      else if (ce)
      begin
         if (tot_clear)
         begin
            // Manual or channel reset, manual needs no enable
            total <= 32'sh0000_0000;
         end
         else if (!tot_hold)
         begin
            // Reversal flips the sign of each increment
            total <= tot_rev ? total - 32'(step) : total + 32'(step);
         end
      end
   end

   // Configuration, limit and interrupt enable registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cfg_reg <= pft_pkg::CFG_RST;
         low_reg <= pft_pkg::LIMIT_RST;
         high_reg <= pft_pkg::LIMIT_RST;
         ev_en_reg <= '0;
      end
      else if (ce && wr)
      begin
         case (addr)
            pft_pkg::OFS_CFG: cfg_reg <= wdata[pft_pkg::CFG_W-1:0];
            pft_pkg::OFS_LOW: low_reg <= wdata;
            pft_pkg::OFS_HIGH: high_reg <= wdata;
            pft_pkg::OFS_IRQ_EN: ev_en_reg <= wdata[pft_pkg::EV_W-1:0];
            default:
            begin
               // Other offsets are read only or write nothing here
            end
         endcase
      end
   end

   // Rising flags and the start of a zero timeout are events
   assign ev_set[pft_pkg::EV_BELOW] = ce && (rate < low_reg) && !below_limit_flag;
   assign ev_set[pft_pkg::EV_ABOVE] = ce && (rate > high_reg) && !above_limit_flag;
   assign ev_set[pft_pkg::EV_ZERO] = ce && zero_hit && !zero_seen_reg;

   // Sticky status; a set in the clear cycle survives
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ev_stat_reg <= '0;
         zero_seen_reg <= 1'b0;
         irq <= 1'b0;
      end
      else if (ce)
      begin
         zero_seen_reg <= zero_hit;
         if (wr && (addr == pft_pkg::OFS_IRQ_CLR))
         begin
            ev_stat_reg <= (ev_stat_reg & ~wdata[pft_pkg::EV_W-1:0]) | ev_set;
         end
         else
         begin
            ev_stat_reg <= ev_stat_reg | ev_set;
         end
         irq <= |(ev_stat_reg & ev_en_reg);
      end
   end

   // Read data stands one cycle after the strobe only
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdata <= pft_pkg::ZERO32;
      end
      else if (ce)
      begin
         rdata <= pft_pkg::ZERO32;
         if (rd)
         begin
            case (addr)
               pft_pkg::OFS_CFG: rdata <= 32'(cfg_reg);
               pft_pkg::OFS_LOW: rdata <= low_reg;
               pft_pkg::OFS_HIGH: rdata <= high_reg;
               pft_pkg::OFS_RATE: rdata <= rate;
               pft_pkg::OFS_TOTAL: rdata <= total;
               pft_pkg::OFS_FLAGS: rdata <= {30'h0, above_limit_flag, below_limit_flag};
               pft_pkg::OFS_IRQ_STAT: rdata <= 32'(ev_stat_reg);
               pft_pkg::OFS_IRQ_EN: rdata <= 32'(ev_en_reg);
               default: rdata <= pft_pkg::ZERO32;
            endcase
         end
      end
   end
endmodule

`default_nettype wire

// *** shared/pft_pkg.sv ***
// Purpose: Constants and types for one pulse flowmeter channel.
// Assumes: 200 MHz system clock, 32-bit register port.
// Notes: Functional notes follow.
// Functional notes
// - Direction mode: count input one only.
// - Direction low counts up, high down.
// - Quad single: one count per cycle.
// - Quad high resolution: four counts per cycle.
// - Selectable filter caps measured pulse frequency.
// - Filter disabled counts without any cap.
// - No pulse within zero time forces rate zero.
// - Rate per second, minute or hour.
// - Below low limit raises low flag.
// - Above high limit raises high flag.
// - Manual reset clears totalizer at once.
// - Reset channel above zero clears totalizer.
// - Hold channel at or below zero freezes total.
// - Direction channel above zero reverses totalizer.
package pft_pkg;

   // Clock
   localparam int CLK_PERIOD_NS = 5;
   localparam int CLK_HZ_DEF = 1000000000 / CLK_PERIOD_NS;

   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_LOW = 8'h08;
   localparam logic [7:0] OFS_HIGH = 8'h0C;
   localparam logic [7:0] OFS_RATE = 8'h10;
   localparam logic [7:0] OFS_TOTAL = 8'h14;
   localparam logic [7:0] OFS_FLAGS = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h20;
   localparam logic [7:0] OFS_IRQ_EN = 8'h24;

   // Command bit positions
   localparam int CMD_RESET_NOW = 0;

   // Event bit positions
   localparam int EV_BELOW = 0;
   localparam int EV_ABOVE = 1;
   localparam int EV_ZERO = 2;
   localparam int EV_W = 3;

   // Counting modes
   typedef enum logic [1:0] {PFT_DIRIN, PFT_QUAD1, PFT_QUAD4} pft_mode_t;

   // Configuration word, low bits of the config register
   typedef struct packed {
      logic dir_en;
      logic hold_en;
      logic rst_en;
      logic [1:0] tbase;
      logic [1:0] zsel;
      logic [3:0] filt;
      logic [1:0] mode;
   } pft_cfg_t;
   localparam int CFG_W = 13;
   localparam logic [CFG_W-1:0] CFG_RST = 13'h0000;

   // Logical channel values feeding the totalizer controls
   typedef struct packed {
      logic signed [31:0] rst_val;
      logic signed [31:0] hold_val;
      logic signed [31:0] dir_val;
   } pft_chan_t;

   // Filter caps in Hz, index 0 means filter disabled
   localparam int FILT_HZ [9] = '{0, 10, 25, 50, 100, 1000, 5000, 10000, 50000};
   // Zero times in ms
   localparam int ZERO_MS [3] = '{100, 1000, 10000};
   // Time base multipliers over a one second gate
   localparam int TBASE_MUL [3] = '{1, 60, 3600};

   // Reset values
   localparam logic [31:0] LIMIT_RST = 32'h0000_0000;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;

endpackage

// *** sim/pft_channel_assertions.sv ***
// Purpose: Port checks for one flow channel.
// Assumes: Shadows of CFG, LOW and HIGH follow accepted writes.
// Notes: Zero check allows filter and sync latency.
`timescale 1ns/10ps
`default_nettype none
module pft_channel_chk
#(
   parameter int CLK_HZ = 1000
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Pins and channels
   input wire logic inp1,
   input wire logic inp2,
   input wire pft_pkg::pft_chan_t chan,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   // Results
   input wire logic signed [31:0] rate,
   input wire logic signed [31:0] total,
   input wire logic below_limit_flag,
   input wire logic above_limit_flag,
   input wire logic irq
);
   pft_pkg::pft_cfg_t cfg_sh;
   logic signed [31:0] low_sh, high_sh;
   logic [31:0] idle, zlim;
   logic p1, p2, clr_now, clr_ch;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Clear causes seen at the ports
   assign clr_now = ce && wr && addr == pft_pkg::OFS_CMD && wdata[0];
   assign clr_ch = cfg_sh.rst_en && chan.rst_val > 32'sd0;
   // Zero time plus worst filter delay, so a slow pin never trips it
   assign zlim = 32'(pft_pkg::ZERO_MS[cfg_sh.zsel == 2'h3 ? 2 : cfg_sh.zsel] * (CLK_HZ / 1000)
      + CLK_HZ / 20 + 16);
   // Register shadows
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cfg_sh <= '0;
         low_sh <= '0;
         high_sh <= '0;
      end
      else if (ce && wr)
      begin
         if (addr == pft_pkg::OFS_CFG) cfg_sh <= pft_pkg::pft_cfg_t'(wdata[12:0]);
         if (addr == pft_pkg::OFS_LOW) low_sh <= wdata;
         if (addr == pft_pkg::OFS_HIGH) high_sh <= wdata;
      end
   end
   // Cycles since either pin last moved
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         p1 <= 1'b0;
         p2 <= 1'b0;
         idle <= '0;
      end
      else
      begin
         p1 <= inp1;
         p2 <= inp2;
         if (inp1 != p1 || inp2 != p2) idle <= '0;
         else if (idle != 32'hFFFF_FFFF) idle <= idle + 32'h1;
      end
   end
   a_rdata_idle: assert property ($past(ce) && !$past(rd) |-> rdata == 32'h0)
      else $error("read data not idle");
   a_rate_read: assert property ($past(rd) && $past(addr) == pft_pkg::OFS_RATE |->
      rdata == $past(rate)) else $error("rate readback wrong");
   a_below_flag: assert property ($past(ce) |->
      below_limit_flag == ($past(rate) < $past(low_sh))) else $error("low flag wrong");
   a_above_flag: assert property ($past(ce) |->
      above_limit_flag == ($past(rate) > $past(high_sh))) else $error("high flag wrong");
   a_reset_now: assert property (clr_now |=> total == 32'sh0)
      else $error("manual clear missed");
   a_chan_reset: assert property (ce && clr_ch |=> total == 32'sh0)
      else $error("channel clear missed");
   a_hold_freeze: assert property (ce && cfg_sh.hold_en && chan.hold_val <= 32'sd0 && !clr_now
      && !clr_ch |=> $stable(total)) else $error("hold did not freeze");
   a_total_step: assert property ($past(ce) && !$past(clr_now || clr_ch) |->
      32'(total - $past(total)) inside {32'h0, 32'h1, 32'hFFFF_FFFF})
      else $error("total jumped");
   a_rate_zero: assert property (ce && idle > zlim |-> rate == 32'sh0)
      else $error("rate not forced to zero");
   c_clear: cover property (clr_now);
   c_above: cover property ($rose(above_limit_flag));
   c_irq: cover property ($rose(irq));
endmodule
bind pft_channel pft_channel_chk #(.CLK_HZ(CLK_HZ)) chk_u (.clk(clk), .rst(rst), .ce(ce),
   .inp1(inp1), .inp2(inp2), .chan(chan), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .rate(rate), .total(total), .below_limit_flag(below_limit_flag),
   .above_limit_flag(above_limit_flag), .irq(irq));
`default_nettype wire

// *** sim/pft_sensor.sv ***
// Purpose: Flow sensor model driving the two counting pins.
// Assumes: Bursts are requested by a one-cycle go strobe.
// Notes: Pins hold their level between bursts.
`timescale 1ns/10ps
`default_nettype none
module pft_sensor
(
   // Clock
   input wire logic clk,
   // Burst request
   input wire logic go,
   input wire logic quad,
   input wire logic rev,
   input wire logic [15:0] npls,
   input wire logic [7:0] half,
   // Pins and status
   output logic inp1,
   output logic inp2,
   output logic busy
);
   int i;
   // Wait some clock edges
   task automatic hw(input int c);
      repeat (c) @(posedge clk);
   endtask
   // Quad: A leads B forward; direction style: pin two gives the sign
   initial
   begin
      inp1 = 1'b0;
      inp2 = 1'b0;
      busy = 1'b0;
      forever
      begin
         @(posedge clk);
         if (go === 1'b1)
         begin
            busy <= 1'b1;
            inp2 <= rev & !quad;
            hw(half);
            for (i = 0; i < npls; i++)
            begin
               inp1 <= quad ? !rev : 1'b1;
               inp2 <= quad ? rev : inp2;
               hw(half);
               if (quad)
               begin
                  inp1 <= 1'b1;
                  inp2 <= 1'b1;
                  hw(half);
                  inp1 <= rev;
                  inp2 <= !rev;
                  hw(half);
               end
               inp1 <= 1'b0;
               inp2 <= quad ? 1'b0 : inp2;
               hw(half);
            end
            // Sign level falls only after the last count edge
            inp2 <= 1'b0;
            hw(half);
            busy <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** sim/test_pft_channel.sv ***
// Purpose: Self-checking bench for one flow channel.
// Assumes: CLK_HZ of 1000, so a rate gate is 1000 cycles.
// Notes: Results are read back and checked from a queue.
`timescale 1ns/10ps
`default_nettype none
module test_pft_channel;
   localparam int HZ = 1000;
   logic clk, rst, ce, inp1, inp2, wr, rd, go, quad, rev, busy, pend;
   logic [7:0] addr, half;
   logic [15:0] npls;
   logic [31:0] wdata, rdata, seed, ex;
   logic signed [31:0] rate, total, tot;
   logic below_limit_flag, above_limit_flag, irq;
   pft_pkg::pft_chan_t chan;
   logic [31:0] exp_q[$];
   string nm_q[$];
   int bad_count, samples_checked, n, k, m, r, mc;
   pft_channel #(.CLK_HZ(HZ)) dut_u (.clk(clk), .rst(rst), .ce(ce), .inp1(inp1),
      .inp2(inp2), .chan(chan), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .rate(rate), .total(total), .below_limit_flag(below_limit_flag),
      .above_limit_flag(above_limit_flag), .irq(irq));
   pft_sensor sen_u (.clk(clk), .go(go), .quad(quad), .rev(rev), .npls(npls), .half(half),
      .inp1(inp1), .inp2(inp2), .busy(busy));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task results;
      $display("compares %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Read data lands one cycle after the strobe
   always @(posedge clk)
      pend <= rd;
   always @(negedge clk)
      if (pend === 1'b1 && nm_q.size() != 0)
         chk(nm_q.pop_front(), exp_q.pop_front(), rdata);
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task rd_reg(input logic [7:0] a, input logic [31:0] e, input string nm);
      exp_q.push_back(e);
      nm_q.push_back(nm);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task pin_chk(input logic e);
      @(negedge clk);
      chk("irq pin", {31'h0, e}, {31'h0, irq});
      @(posedge clk);
   endtask
   task launch(input logic q, input logic v, input int c, input int h);
      quad <= q;
      rev <= v;
      npls <= 16'(c);
      half <= 8'(h);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
   endtask
   // Bounded wait for the burst, then room for filter latency
   task pwait;
      k = 0;
      while (busy === 1'b1 && k < 30000)
      begin
         @(posedge clk);
         k++;
      end
      if (k >= 30000)
      begin
         bad_count++;
         results();
      end
      repeat (70) @(posedge clk);
   endtask
   // One totalizer control case; eff 2 means cleared
   task tcase(input logic [31:0] cfg, input int rv, hv, dv, input logic v, input int eff);
      chan <= {32'(rv), 32'(hv), 32'(dv)};
      wr_reg(pft_pkg::OFS_CFG, cfg);
      n = 1 + int'(seed % 9);
      seed = xs(seed);
      launch(1'b0, v, n, 4);
      pwait();
      tot = (eff == 2) ? 32'sh0 : tot + eff * n;
      rd_reg(pft_pkg::OFS_TOTAL, tot, "total control");
   endtask
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      go = 1'b0;
      quad = 1'b0;
      rev = 1'b0;
      npls = '0;
      half = 8'h4;
      addr = '0;
      wdata = '0;
      chan = '0;
      seed = 32'd64582;
      tot = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_reg(pft_pkg::OFS_CFG, 32'h0, "cfg reset");
      rd_reg(pft_pkg::OFS_LOW, 32'h0, "low reset");
      rd_reg(pft_pkg::OFS_IRQ_EN, 32'h0, "irq en reset");
      rd_reg(8'h3C, 32'h0, "unmapped");
      wr_reg(pft_pkg::OFS_TOTAL, 32'h55);
      rd_reg(pft_pkg::OFS_TOTAL, 32'h0, "total ro");
      for (m = 0; m < 3; m++)
         for (r = 0; r < 2; r++)
         begin
            wr_reg(pft_pkg::OFS_CFG, 32'(m));
            n = 1 + int'(seed % 8);
            seed = xs(seed);
            launch(m != 0, r[0], n, 4);
            pwait();
            tot = tot + (r ? -n : n) * (m == 2 ? 4 : 1);
            rd_reg(pft_pkg::OFS_TOTAL, tot, "total mode");
         end
      $display("counting modes done");
      for (m = 0; m < 9; m++)
      begin
         mc = (m == 0) ? 0 : HZ / (2 * pft_pkg::FILT_HZ[m]);
         wr_reg(pft_pkg::OFS_CFG, 32'(m << 2));
         if (mc > 2)
            launch(1'b0, 1'b0, 3, mc / 2);
         pwait();
         launch(1'b0, 1'b0, 2, mc + 6);
         pwait();
         tot = tot + 2;
         rd_reg(pft_pkg::OFS_TOTAL, tot, "total filter");
      end
      $display("filter done");
      wr_reg(pft_pkg::OFS_LOW, 32'd200);
      wr_reg(pft_pkg::OFS_HIGH, 32'd5000);
      for (m = 0; m < 3; m++)
      begin
         wr_reg(pft_pkg::OFS_CFG, 32'(m << 8));
         launch(1'b0, 1'b0, 250, 5);
         repeat (2200) @(posedge clk);
         ex = 32'(100 * pft_pkg::TBASE_MUL[m]);
         rd_reg(pft_pkg::OFS_RATE, ex, "rate");
         rd_reg(pft_pkg::OFS_FLAGS, {30'h0, ex > 32'd5000, ex < 32'd200}, "flags");
         pwait();
         tot = tot + 250;
         rd_reg(pft_pkg::OFS_TOTAL, tot, "total rate");
         repeat (150) @(posedge clk);
         rd_reg(pft_pkg::OFS_RATE, 32'h0, "rate zero");
      end
      $display("rate done");
      rd_reg(pft_pkg::OFS_IRQ_STAT, 32'h7, "irq stat");
      pin_chk(1'b0);
      wr_reg(pft_pkg::OFS_IRQ_EN, 32'h7);
      pin_chk(1'b1);
      wr_reg(pft_pkg::OFS_IRQ_EN, 32'h0);
      pin_chk(1'b0);
      wr_reg(pft_pkg::OFS_IRQ_EN, 32'h7);
      wr_reg(pft_pkg::OFS_IRQ_CLR, 32'h7);
      rd_reg(pft_pkg::OFS_IRQ_STAT, 32'h0, "irq cleared");
      pin_chk(1'b0);
      $display("interrupt done");
      wr_reg(pft_pkg::OFS_CMD, 32'h1);
      tot = 0;
      rd_reg(pft_pkg::OFS_TOTAL, tot, "total clear");
      tcase(32'h400, 7, 0, 0, 1'b0, 2);
      tcase(32'h400, 0, 0, 0, 1'b0, 1);
      tcase(32'h800, 0, 0, 0, 1'b0, 0);
      tcase(32'h800, 0, -3, 0, 1'b0, 0);
      tcase(32'h800, 0, 1, 0, 1'b0, 1);
      tcase(32'h1000, 0, 0, 9, 1'b0, -1);
      tcase(32'h1000, 0, 0, 9, 1'b1, 1);
      tcase(32'h1000, 0, 0, 0, 1'b1, -1);
      tcase(32'h1C00, 2, 0, 0, 1'b0, 2);
      $display("totalizer done");
      repeat (4) @(posedge clk);
      results();
   end
endmodule
`default_nettype wire
